// >>> dv/motion_model.sv
// Motion logic stand-in that answers the sequencer's move port.
// Assumes the sequencer's clock and reset.
`timescale 1ns/1ps
module motion_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic move_start,
    output logic move_done,
    output logic smooth_zero
);
    logic [4:0] cnt_reg;
    // Smoothing settles well after done, so a reversal must really wait
    assign smooth_zero = (cnt_reg == 5'h00);
    assign move_done = (cnt_reg == 5'h05);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 5'h00;
        end else if (move_start) begin
            cnt_reg <= 5'h14;
        end else if (cnt_reg != 5'h00) begin
            cnt_reg <= cnt_reg - 5'h01;
        end
    end
endmodule

// >>> dv/testbench.sv
// Self-checking bench: AXI4-Lite master, start pins and motion stand-in.
// Assumes rtl/ and dv/motion_model.sv compile first.
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rst_n = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic fs = 1'b0, amode = 1'b0, awr, wy, bv, arr, rv, ms, sz, md, irq;
    logic [7:0] aw = 8'h00, ar = 8'h00, sel = 8'h00;
    logic [31:0] wd = 32'h0, rdat;
    logic signed [31:0] mt, tgt;
    logic [1:0] br, rr;
    logic [15:0] spd, sp, msp;
    logic [14:0] acc, dec;
    logic [47:0] q[$];
    int errors = 0, comparisons = 0, n;
    initial forever #10 clk = ~clk;
    point_table_sequencer #(.CYCLES_PER_MS(10)) i_dut (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(aw),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
        .s_axi_wready(wy), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bready), .s_axi_araddr(ar),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rready), .forward_start_input(fs), .auto_manual_select_input(amode),
        .entry_select_input(sel), .move_done(md), .smooth_zero(sz), .move_start(ms), .move_target(mt),
        .move_speed(msp), .move_accel(acc), .move_decel(dec), .irq(irq));
    motion_model i_motion (.clk(clk), .rst_n(rst_n), .move_start(ms), .move_done(md), .smooth_zero(sz));
    task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic finish_test;
        if (errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tmo;
        if (n >= 400) begin
            check("wait", 32'h0, 32'h1);
            finish_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        aw <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (awr && awv) awv <= 1'b0;
            if (wy && wv) wv <= 1'b0;
        end while (bv !== 1'b1 && n < 400);
        tmo();
        check("bresp", 32'(br), 32'(r));
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input logic [1:0] r);
        ar <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
            if (arr) arv <= 1'b0;
        end while (rv !== 1'b1 && n < 400);
        tmo();
        check("rresp", 32'(rr), 32'(r));
        check("rdata", rdat & m, e);
    endtask
    task automatic ent(input logic [7:0] i, input logic [31:0] p, input logic [1:0] x, input logic [31:0] dw);
        spd = 16'($urandom) & 16'h0fff;
        wr(pts_pkg::TBL_INDEX_OFF, {24'h0, i}, pts_pkg::RESP_OKAY);
        wr(pts_pkg::TBL_POS_OFF, p, pts_pkg::RESP_OKAY);
        rd(pts_pkg::TBL_POS_OFF, 32'hffffffff, p, pts_pkg::RESP_OKAY);
        wr(pts_pkg::TBL_SPEED_OFF, {16'h0, spd}, pts_pkg::RESP_OKAY);
        wr(pts_pkg::TBL_ACCEL_OFF, 32'h4e20, pts_pkg::RESP_OKAY);
        wr(pts_pkg::TBL_DECEL_OFF, 32'h1388, pts_pkg::RESP_OKAY);
        wr(pts_pkg::TBL_DWELL_OFF, dw, pts_pkg::RESP_OKAY);
        wr(pts_pkg::TBL_AUX_OFF, {30'h0, x}, pts_pkg::RESP_OKAY);
    endtask
    task automatic go(input logic [7:0] e, input logic [31:0] st, input logic regm);
        if (regm) begin
            wr(pts_pkg::CTRL_OFF, 32'h13, pts_pkg::RESP_OKAY);
        end else begin
            sel <= e;
            @(posedge clk);
            fs <= 1'b1;
            repeat (4) @(posedge clk);
            fs <= 1'b0;
        end
        n = 0;
        while ((q.size() != 0 || irq !== 1'b1) && n < 400) begin
            @(posedge clk);
            n++;
        end
        tmo();
        rd(pts_pkg::IRQ_STAT_OFF, 32'h7, st, pts_pkg::RESP_OKAY);
        rd(pts_pkg::STATUS_OFF, 32'h7, 32'h0, pts_pkg::RESP_OKAY);
        wr(pts_pkg::IRQ_STAT_OFF, 32'h7, pts_pkg::RESP_OKAY);
        @(posedge clk);
        check("irq", 32'(irq), 32'h0);
    endtask
    always @(posedge clk) begin
        if (ms === 1'b1 && q.size() == 0) begin
            check("move_start", 32'h1, 32'h0);
        end else if (ms === 1'b1) begin
            {tgt, sp} = q.pop_front();
            check("move_target", mt, tgt);
            check("move_speed", 32'(msp), 32'(sp));
            check("move_accel", 32'(acc), 32'h4e20);
            check("move_decel", 32'(dec), 32'h1388);
        end
    end
    initial begin
        void'($urandom(92));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        amode <= 1'b1;
        @(posedge clk);
        rd(pts_pkg::IRQ_MASK_OFF, 32'h7, 32'h0, pts_pkg::RESP_OKAY);
        wr(pts_pkg::IRQ_MASK_OFF, 32'h3, pts_pkg::RESP_OKAY);
        wr(pts_pkg::CTRL_OFF, 32'h10, pts_pkg::RESP_OKAY);
        ent(8'h01, 32'ha, 2'h1, 32'h0);
        q.push_back({32'h64, spd});
        ent(8'h02, -32'sh3, 2'h3, 32'h1);
        q.push_back({32'h46, spd});
        ent(8'h03, 32'h4, 2'h2, 32'h0);
        q.push_back({32'h6e, spd});
        go(8'h01, 32'h1, 1'b0);
        for (int s = 0; s < 4; s++) begin
            wr(pts_pkg::CTRL_OFF, 32'(s) << 4, pts_pkg::RESP_OKAY);
            ent(8'h04, -pts_pkg::POS_MAX, 2'h0, 32'h4e20);
            q.push_back({-pts_pkg::POS_MAX * 32'(10 ** s), spd});
            go(8'h04, 32'h1, 1'b0);
        end
        wr(pts_pkg::CTRL_OFF, 32'h11, pts_pkg::RESP_OKAY);
        wr(pts_pkg::SELECT_OFF, 32'h2, pts_pkg::RESP_OKAY);
        ent(8'h02, -32'sh3, 2'h3, 32'h1);
        q.push_back({-pts_pkg::POS_MAX * 32'h3e8 - 32'sh1e, spd});
        go(8'h02, 32'h1, 1'b1);
        wr(pts_pkg::CTRL_OFF, 32'h10, pts_pkg::RESP_OKAY);
        ent(8'hff, 32'h1, 2'h1, 32'h0);
        go(8'hff, 32'h2, 1'b0);
        wr(pts_pkg::TBL_POS_OFF, 32'hf4240, pts_pkg::RESP_SLVERR);
        wr(pts_pkg::TBL_ACCEL_OFF, 32'h4e21, pts_pkg::RESP_SLVERR);
        wr(pts_pkg::TBL_DECEL_OFF, 32'h4e21, pts_pkg::RESP_SLVERR);
        wr(pts_pkg::TBL_DWELL_OFF, 32'h4e21, pts_pkg::RESP_SLVERR);
        rd(8'h3c, 32'h0, 32'h0, pts_pkg::RESP_SLVERR);
        rd(pts_pkg::IRQ_STAT_OFF, 32'h7, 32'h4, pts_pkg::RESP_OKAY);
        check("irq", 32'(irq), 32'h0);
        finish_test();
    end
endmodule

// >>> rtl/point_table_sequencer.sv
// Point-table positioning sequencer with AXI4-Lite table access.
// Assumes move_done and smooth_zero come from motion logic on clk;
// start, mode and selection pins are asynchronous and synchronised here.
`timescale 1ns/1ps

// Operation
// - Absolute entry: scaled position is target address
// - Incremental entry: signed travel, negative reverses
// - Acceleration constant accepted from 0 to 20000
// - Deceleration constant accepted from 0 to 20000
// - Finish move, wait dwell, start next
// - Aux code 0 ignores dwell
// - Aux 1 with zero dwell chains immediately
// - Absolute: code 0 single, 1 chained
// - Incremental: code 2 single, 3 chained
// - Reversal within a chained run waits for smoothed command zero; the first entry of a run never waits
// - Entry 255 with chaining raises error
// - Register selection disables dwell and chaining
// - Every table field writable over the bus
// - Scale exponent selects 1/10/100/1000 micrometres
module point_table_sequencer #(
    parameter int CYCLES_PER_MS = pts_pkg::CYCLES_PER_MS
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic forward_start_input,
    input wire logic auto_manual_select_input,
    input wire logic [7:0] entry_select_input,
    input wire logic move_done,
    input wire logic smooth_zero,
    output logic move_start,
    output logic signed [31:0] move_target,
    output logic [15:0] move_speed,
    output logic [14:0] move_accel,
    output logic [14:0] move_decel,
    output logic irq
);
    // Table storage; entry 0 exists but is never run
    logic signed [20:0] pos_mem [256];
    logic [15:0] speed_mem [256];
    logic [14:0] accel_mem [256];
    logic [14:0] decel_mem [256];
    logic [14:0] dwell_mem [256];
    logic [1:0] aux_mem [256];

    function automatic logic signed [31:0] scale_pos(input logic signed [20:0] p, input logic [1:0] e);
        logic signed [31:0] w;
        w = 32'(p);
        unique case (e)
            2'd0: scale_pos = w;
            2'd1: scale_pos = w * 32'sd10;
            2'd2: scale_pos = w * 32'sd100;
            2'd3: scale_pos = w * 32'sd1000;
        endcase
    endfunction

    // Pin synchronisers
    logic fs_meta, fs_sync, fs_prev, am_meta, am_sync;
    logic [7:0] sel_meta, sel_sync;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fs_meta <= 1'b0;
            fs_sync <= 1'b0;
            fs_prev <= 1'b0;
            am_meta <= 1'b0;
            am_sync <= 1'b0;
            sel_meta <= 8'h00;
            sel_sync <= 8'h00;
        end else begin
            fs_meta <= forward_start_input;
            fs_sync <= fs_meta;
            fs_prev <= fs_sync;
            am_meta <= auto_manual_select_input;
            am_sync <= am_meta;
            sel_meta <= entry_select_input;
            sel_sync <= sel_meta;
        end
    end

    // Bus and register state
    logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
    logic [7:0] aw_addr_reg, aw_addr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [5:0] ctrl_reg, ctrl_next;
    logic [7:0] select_reg, select_next, tbl_idx_reg, tbl_idx_next;
    logic [2:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next, irq_set;
    logic irq_reg, irq_next, do_write, wr_ok, soft_start;
    // Sequencer state
    pts_pkg::seq_state_e state_reg, state_next;
    logic [7:0] entry_reg, entry_next;
    logic by_reg_reg, by_reg_next, chain_reg, chain_next, incr_reg, incr_next;
    logic rev_reg, rev_next, dir_neg_reg, dir_neg_next, moved_reg, moved_next;
    logic signed [31:0] cur_pos_reg, cur_pos_next, target_reg, target_next, scaled;
    logic [15:0] speed_reg, speed_next, pre_reg, pre_next;
    logic [14:0] accel_reg, accel_next, decel_reg, decel_next, dwell_reg, dwell_next, ms_reg, ms_next;
    logic start_reg, start_next, pin_start, new_neg;

    assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

    always_comb begin
        aw_have_next = aw_have_reg;
        w_have_next = w_have_reg;
        aw_addr_next = aw_addr_reg;
        wdata_next = wdata_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        ctrl_next = ctrl_reg;
        ctrl_next[pts_pkg::CTRL_START_BIT] = 1'b0;
        select_next = select_reg;
        tbl_idx_next = tbl_idx_reg;
        irq_mask_next = irq_mask_reg;
        soft_start = 1'b0;
        wr_ok = 1'b1;
        if (s_axi_awvalid && !aw_have_reg) begin
            aw_have_next = 1'b1;
            aw_addr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_have_reg) begin
            w_have_next = 1'b1;
            wdata_next = s_axi_wdata;
        end
        if (s_axi_bready && bvalid_reg) begin
            bvalid_next = 1'b0;
        end
        if (do_write) begin
            aw_have_next = 1'b0;
            w_have_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = pts_pkg::RESP_OKAY;
            unique case (aw_addr_reg)
                pts_pkg::CTRL_OFF: begin
                    ctrl_next = wdata_reg[5:0];
                    // Start is a strobe only, so it never reads back as set
                    ctrl_next[pts_pkg::CTRL_START_BIT] = 1'b0;
                    soft_start = wdata_reg[pts_pkg::CTRL_START_BIT];
                end
                pts_pkg::SELECT_OFF: select_next = wdata_reg[7:0];
                pts_pkg::TBL_INDEX_OFF: tbl_idx_next = wdata_reg[7:0];
                pts_pkg::TBL_POS_OFF: wr_ok = $signed(wdata_reg) <= pts_pkg::POS_MAX
                    && $signed(wdata_reg) >= -pts_pkg::POS_MAX;
                pts_pkg::TBL_ACCEL_OFF, pts_pkg::TBL_DECEL_OFF,
                pts_pkg::TBL_DWELL_OFF: wr_ok = wdata_reg <= pts_pkg::TIME_MAX_MS;
                pts_pkg::TBL_SPEED_OFF, pts_pkg::TBL_AUX_OFF, pts_pkg::IRQ_STAT_OFF: ;
                pts_pkg::IRQ_MASK_OFF: irq_mask_next = wdata_reg[2:0];
                default: bresp_next = pts_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_rready && rvalid_reg) begin
            rvalid_next = 1'b0;
        end else if (s_axi_arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = pts_pkg::RESP_OKAY;
            rdata_next = 32'h0;
            unique case (s_axi_araddr)
                pts_pkg::CTRL_OFF: rdata_next[5:0] = ctrl_reg;
                pts_pkg::SELECT_OFF: rdata_next[7:0] = select_reg;
                pts_pkg::TBL_INDEX_OFF: rdata_next[7:0] = tbl_idx_reg;
                pts_pkg::TBL_POS_OFF: rdata_next = 32'(pos_mem[tbl_idx_reg]);
                pts_pkg::TBL_SPEED_OFF: rdata_next[15:0] = speed_mem[tbl_idx_reg];
                pts_pkg::TBL_ACCEL_OFF: rdata_next[14:0] = accel_mem[tbl_idx_reg];
                pts_pkg::TBL_DECEL_OFF: rdata_next[14:0] = decel_mem[tbl_idx_reg];
                pts_pkg::TBL_DWELL_OFF: rdata_next[14:0] = dwell_mem[tbl_idx_reg];
                pts_pkg::TBL_AUX_OFF: rdata_next[1:0] = aux_mem[tbl_idx_reg];
                pts_pkg::STATUS_OFF: rdata_next[15:0] = {entry_reg, 3'b000, dir_neg_reg, 1'b0, state_reg};
                pts_pkg::IRQ_STAT_OFF: rdata_next[2:0] = irq_stat_reg;
                pts_pkg::IRQ_MASK_OFF: rdata_next[2:0] = irq_mask_reg;
                pts_pkg::TARGET_OFF: rdata_next = target_reg;
                default: rresp_next = pts_pkg::RESP_SLVERR;
            endcase
        end
        if (!wr_ok) begin
            bresp_next = pts_pkg::RESP_SLVERR;
        end
    end

    // Out-of-range values are refused so the sequencer never runs an illegal entry
    always_ff @(posedge clk) begin
        if (do_write && wr_ok) begin
            unique case (aw_addr_reg)
                pts_pkg::TBL_POS_OFF: pos_mem[tbl_idx_reg] <= wdata_reg[20:0];
                pts_pkg::TBL_SPEED_OFF: speed_mem[tbl_idx_reg] <= wdata_reg[15:0];
                pts_pkg::TBL_ACCEL_OFF: accel_mem[tbl_idx_reg] <= wdata_reg[14:0];
                pts_pkg::TBL_DECEL_OFF: decel_mem[tbl_idx_reg] <= wdata_reg[14:0];
                pts_pkg::TBL_DWELL_OFF: dwell_mem[tbl_idx_reg] <= wdata_reg[14:0];
                pts_pkg::TBL_AUX_OFF: aux_mem[tbl_idx_reg] <= wdata_reg[1:0];
                default: ;
            endcase
        end
    end

    // Sequencer
    assign pin_start = fs_sync && !fs_prev;
    always_comb begin
        state_next = state_reg;
        entry_next = entry_reg;
        by_reg_next = by_reg_reg;
        chain_next = chain_reg;
        incr_next = incr_reg;
        rev_next = rev_reg;
        dir_neg_next = dir_neg_reg;
        moved_next = moved_reg;
        cur_pos_next = cur_pos_reg;
        target_next = target_reg;
        speed_next = speed_reg;
        accel_next = accel_reg;
        decel_next = decel_reg;
        dwell_next = dwell_reg;
        ms_next = ms_reg;
        pre_next = pre_reg;
        start_next = 1'b0;
        irq_set = 3'b000;
        irq_set[pts_pkg::IRQ_RANGE_ERR_BIT] = do_write && !wr_ok;
        scaled = scale_pos(pos_mem[entry_reg], ctrl_reg[pts_pkg::CTRL_SCALE_LSB +: 2]);
        new_neg = incr_reg ? scaled < 32'sd0 : scaled < cur_pos_reg;
        unique case (state_reg)
            pts_pkg::S_IDLE: begin
                moved_next = 1'b0;
                if (am_sync && ctrl_reg[pts_pkg::CTRL_REGSEL_BIT] && soft_start) begin
                    entry_next = select_reg;
                    by_reg_next = 1'b1;
                    state_next = pts_pkg::S_LOAD;
                end else if (am_sync && !ctrl_reg[pts_pkg::CTRL_REGSEL_BIT] && pin_start) begin
                    entry_next = sel_sync;
                    by_reg_next = 1'b0;
                    state_next = pts_pkg::S_LOAD;
                end
            end
            pts_pkg::S_LOAD: begin
                incr_next = aux_mem[entry_reg][pts_pkg::AUX_INCR_BIT];
                chain_next = aux_mem[entry_reg][pts_pkg::AUX_CHAIN_BIT] && !by_reg_reg;
                dwell_next = dwell_mem[entry_reg];
                speed_next = speed_mem[entry_reg];
                accel_next = accel_mem[entry_reg];
                decel_next = decel_mem[entry_reg];
                if (aux_mem[entry_reg][pts_pkg::AUX_INCR_BIT]) begin
                    target_next = cur_pos_reg + scaled;
                    new_neg = scaled < 32'sd0;
                end else begin
                    target_next = scaled;
                    new_neg = scaled < cur_pos_reg;
                end
                rev_next = moved_reg && (target_next != cur_pos_reg) && (new_neg != dir_neg_reg);
                if (target_next != cur_pos_reg) begin
                    dir_neg_next = new_neg;
                end
                if (entry_reg == 8'h00 || (chain_next && entry_reg == pts_pkg::LAST_ENTRY)) begin
                    irq_set[pts_pkg::IRQ_CHAIN_ERR_BIT] = 1'b1;
                    state_next = pts_pkg::S_IDLE;
                end else begin
                    state_next = pts_pkg::S_ALIGN;
                end
            end
            pts_pkg::S_ALIGN: begin
                if (!rev_reg || smooth_zero) begin
                    start_next = 1'b1;
                    cur_pos_next = target_reg;
                    moved_next = 1'b1;
                    state_next = pts_pkg::S_MOVE;
                end
            end
            pts_pkg::S_MOVE: begin
                if (move_done) begin
                    if (!chain_reg) begin
                        irq_set[pts_pkg::IRQ_DONE_BIT] = 1'b1;
                        state_next = pts_pkg::S_IDLE;
                    end else if (dwell_reg == 15'h0) begin
                        entry_next = entry_reg + 8'h01;
                        state_next = pts_pkg::S_LOAD;
                    end else begin
                        ms_next = dwell_reg;
                        pre_next = 16'h0;
                        state_next = pts_pkg::S_DWELL;
                    end
                end
            end
            pts_pkg::S_DWELL: begin
                pre_next = pre_reg + 16'h1;
                if (pre_reg == 16'(CYCLES_PER_MS - 1)) begin
                    pre_next = 16'h0;
                    ms_next = ms_reg - 15'h1;
                    if (ms_reg == 15'h1) begin
                        entry_next = entry_reg + 8'h01;
                        state_next = pts_pkg::S_LOAD;
                    end
                end
            end
            default: state_next = pts_pkg::S_IDLE;
        endcase
        // Set wins over a write-one clear in the same cycle
        irq_stat_next = irq_stat_reg;
        if (do_write && aw_addr_reg == pts_pkg::IRQ_STAT_OFF) begin
            irq_stat_next = irq_stat_reg & ~wdata_reg[2:0];
        end
        irq_stat_next = irq_stat_next | irq_set;
        irq_next = |(irq_stat_next & irq_mask_next);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= 8'h00;
            wdata_reg <= 32'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= 2'b00;
            rvalid_reg <= 1'b0;
            rresp_reg <= 2'b00;
            rdata_reg <= 32'h0;
            ctrl_reg <= pts_pkg::CTRL_RST;
            select_reg <= 8'h00;
            tbl_idx_reg <= 8'h00;
            irq_stat_reg <= 3'h0;
            irq_mask_reg <= pts_pkg::IRQ_MASK_RST;
            irq_reg <= 1'b0;
            state_reg <= pts_pkg::S_IDLE;
            entry_reg <= 8'h00;
            by_reg_reg <= 1'b0;
            chain_reg <= 1'b0;
            incr_reg <= 1'b0;
            rev_reg <= 1'b0;
            dir_neg_reg <= 1'b0;
            moved_reg <= 1'b0;
            cur_pos_reg <= 32'sd0;
            target_reg <= 32'sd0;
            speed_reg <= 16'h0;
            accel_reg <= 15'h0;
            decel_reg <= 15'h0;
            dwell_reg <= 15'h0;
            ms_reg <= 15'h0;
            pre_reg <= 16'h0;
            start_reg <= 1'b0;
        end else begin
            aw_have_reg <= aw_have_next;
            w_have_reg <= w_have_next;
            aw_addr_reg <= aw_addr_next;
            wdata_reg <= wdata_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            select_reg <= select_next;
            tbl_idx_reg <= tbl_idx_next;
            irq_stat_reg <= irq_stat_next;
            irq_mask_reg <= irq_mask_next;
            irq_reg <= irq_next;
            state_reg <= state_next;
            entry_reg <= entry_next;
            by_reg_reg <= by_reg_next;
            chain_reg <= chain_next;
            incr_reg <= incr_next;
            rev_reg <= rev_next;
            dir_neg_reg <= dir_neg_next;
            moved_reg <= moved_next;
            cur_pos_reg <= cur_pos_next;
            target_reg <= target_next;
            speed_reg <= speed_next;
            accel_reg <= accel_next;
            decel_reg <= decel_next;
            dwell_reg <= dwell_next;
            ms_reg <= ms_next;
            pre_reg <= pre_next;
            start_reg <= start_next;
        end
    end

    assign s_axi_awready = !aw_have_reg;
    assign s_axi_wready = !w_have_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign move_start = start_reg;
    assign move_target = target_reg;
    assign move_speed = speed_reg;
    assign move_accel = accel_reg;
    assign move_decel = decel_reg;
    assign irq = irq_reg;

    abs_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_LOAD && !aux_mem[entry_reg][1] |=> target_reg == $past(scaled))
        else $error("absolute target mismatch");
    incr_target_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_LOAD && aux_mem[entry_reg][1] |=> target_reg == $past(cur_pos_reg) + $past(scaled))
        else $error("incremental target mismatch");
    time_range_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_write && aw_addr_reg == pts_pkg::TBL_ACCEL_OFF && wdata_reg > pts_pkg::TIME_MAX_MS
        |=> irq_stat_reg[pts_pkg::IRQ_RANGE_ERR_BIT] && s_axi_bresp == pts_pkg::RESP_SLVERR)
        else $error("over-range time accepted");
    dwell_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_MOVE && move_done && chain_reg && dwell_reg != 15'h0
        |=> (state_reg == pts_pkg::S_DWELL) [*2])
        else $error("dwell not held");
    no_dwell_chain_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_MOVE && move_done && chain_reg && dwell_reg == 15'h0
        |=> state_reg == pts_pkg::S_LOAD && entry_reg == $past(entry_reg) + 8'h01)
        else $error("zero dwell chain failed");
    reverse_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_ALIGN && rev_reg && !smooth_zero |=> !move_start)
        else $error("reversal without zero");
    last_entry_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_LOAD && entry_reg == pts_pkg::LAST_ENTRY && aux_mem[entry_reg][0] && !by_reg_reg
        |=> irq_stat_reg[pts_pkg::IRQ_CHAIN_ERR_BIT] && state_reg == pts_pkg::S_IDLE)
        else $error("entry 255 chain not flagged");
    reg_select_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_MOVE && by_reg_reg && move_done |=> state_reg == pts_pkg::S_IDLE)
        else $error("register selection chained");
    single_done_a: assert property (@(posedge clk) disable iff (!rst_n)
        state_reg == pts_pkg::S_MOVE && move_done && !chain_reg
        |=> state_reg == pts_pkg::S_IDLE && irq_stat_reg[pts_pkg::IRQ_DONE_BIT])
        else $error("single entry did not end");
endmodule

// >>> rtl/pts_pkg.sv
// Constants, register map and state codes of the point-table sequencer.
// Assumes a 50 MHz clock and a 32-bit AXI4-Lite register port.
package pts_pkg;
    localparam logic [7:0] CTRL_OFF = 8'h00;
    localparam logic [7:0] SELECT_OFF = 8'h04;
    localparam logic [7:0] TBL_INDEX_OFF = 8'h08;
    localparam logic [7:0] TBL_POS_OFF = 8'h0c;
    localparam logic [7:0] TBL_SPEED_OFF = 8'h10;
    localparam logic [7:0] TBL_ACCEL_OFF = 8'h14;
    localparam logic [7:0] TBL_DECEL_OFF = 8'h18;
    localparam logic [7:0] TBL_DWELL_OFF = 8'h1c;
    localparam logic [7:0] TBL_AUX_OFF = 8'h20;
    localparam logic [7:0] STATUS_OFF = 8'h24;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h28;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h2c;
    localparam logic [7:0] TARGET_OFF = 8'h30;
    localparam int CTRL_REGSEL_BIT = 0;
    localparam int CTRL_START_BIT = 1;
    localparam int CTRL_SCALE_LSB = 4;
    localparam int AUX_CHAIN_BIT = 0;
    localparam int AUX_INCR_BIT = 1;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_CHAIN_ERR_BIT = 1;
    localparam int IRQ_RANGE_ERR_BIT = 2;
    localparam logic [5:0] CTRL_RST = 6'h00;
    localparam logic [2:0] IRQ_MASK_RST = 3'h0;
    localparam logic signed [31:0] POS_MAX = 32'sd999999;
    localparam logic [31:0] TIME_MAX_MS = 32'd20000;
    localparam logic [7:0] LAST_ENTRY = 8'hff;
    localparam int CLK_HZ = 50000000;
    localparam int DWELL_TICK_MS = 1;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000 * DWELL_TICK_MS;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_LOAD = 3'b001,
        S_ALIGN = 3'b010,
        S_MOVE = 3'b011,
        S_DWELL = 3'b100
    } seq_state_e;
endpackage
